/* design/sps_pkg.sv */
// Shared constants and types of the soak program sequencer
package sps_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SOAK   = 8'h04;
  localparam logic [7:0] OFF_BAND   = 8'h08;
  localparam logic [7:0] OFF_CMD    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_REMAIN = 8'h14;
  localparam logic [7:0] OFF_OUTMAP = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_PAT_LO = 0;
  localparam int unsigned CTRL_REQ    = 2;
  localparam int unsigned CTRL_HOURS  = 3;
  localparam int unsigned CTRL_EVT    = 4;
  localparam int unsigned CTRL_ANALOG = 5;
  localparam int unsigned CTRL_RUN    = 6;
  localparam int unsigned CMD_START   = 0;
  localparam int unsigned CMD_RESET   = 1;

  // ---------------------------------------------------------------
  // Limits and reset values
  // ---------------------------------------------------------------
  localparam logic [13:0] SOAK_MIN   = 14'h0001;
  localparam logic [13:0] SOAK_MAX   = 14'h270F;
  localparam logic [13:0] BAND_MAX   = 14'h270F;
  localparam logic [13:0] SOAK_RESET = 14'h0001;
  localparam logic [13:0] BAND_OFF   = 14'h0000;
  localparam int unsigned NOUT       = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ      = 125_000_000;
  localparam longint unsigned HALF_S_MS   = 500;
  localparam int unsigned     HALF_S_CYC  =
    int'(CLK_HZ * HALF_S_MS / 1000);
  localparam int unsigned     MIN_HALVES  = 120;
  localparam int unsigned     HOUR_HALVES = 7200;
  localparam int unsigned     PRE_W       = 27;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPS_PAT_OFF             = 2'h0,
    SPS_PAT_STOP_AT_FINISH  = 2'h1,
    SPS_KEEP_RUNNING_AT_FINISH = 2'h2
  } sps_pattern_t;

  typedef enum logic [1:0] {SPS_IDLE, SPS_SOAK, SPS_DONE} sps_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sps_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sps_apb_rsp_t;

endpackage

/* design/sps_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sps_sync_st_t;

  sps_sync_st_t s;
  sps_sync_st_t next_s;

  // ---------------------------------------------------------------
  // First stage feeds only the second stage
  // ---------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.meta   = pin;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.stable;

endmodule
`default_nettype wire

/* design/sps_tick_gen.sv */
// Half-second prescaler and gated minute or hour tick
`timescale 1ns/1ps
`default_nettype none
module sps_tick_gen #(
  parameter int unsigned HALF_CYC    = sps_pkg::HALF_S_CYC,
  parameter int unsigned MIN_HALVES  = sps_pkg::MIN_HALVES,
  parameter int unsigned HOUR_HALVES = sps_pkg::HOUR_HALVES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic en,
  input  wire logic clr,
  input  wire logic hours,
  output var  logic half_tick,
  output var  logic unit_tick
);

  typedef struct packed {
    logic [sps_pkg::PRE_W-1:0] pre;
    logic                      half;
    logic [12:0]               sub;
    logic                      unit;
  } sps_tick_st_t;

  sps_tick_st_t s;
  sps_tick_st_t next_s;
  logic         wrap;
  logic [12:0]  last;

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  // Prescaler runs free, so a unit is resolved to half a second only
  always_comb begin
    next_s      = s;
    wrap        = (s.pre == sps_pkg::PRE_W'(HALF_CYC - 1));
    last        = hours ? 13'(HOUR_HALVES - 1) : 13'(MIN_HALVES - 1);
    next_s.pre  = wrap ? '0 : s.pre + 1'b1;
    next_s.half = wrap;
    next_s.unit = 1'b0;
    if (clr) begin
      next_s.sub = '0;
    end else if (en && wrap) begin
      if (s.sub >= last) begin
        next_s.sub  = '0;
        next_s.unit = 1'b1;
      end else begin
        next_s.sub = s.sub + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign half_tick = s.half;
  assign unit_tick = s.unit;

endmodule
`default_nettype wire

/* design/sps_top.sv */
// Soak program sequencer with APB register access
//
// Notes on behaviour
// - Run request going from cleared to active starts a soak run.
// - Soak time reaching duration raises the end output and end display.
// - Pattern off: no program operation, start requests are ignored.
// - Stop-at-finish pattern: control goes to stop when the run ends.
// - Keep-running pattern: control stays in run when the run ends.
// - Wait band is off or 1 to 9999 tenths of a degree or hundredths.
// - Soak timer runs only with process value inside set point +/- band.
// - Band off counts as unbounded; timing runs continuously from start.
// - Start from run request, assigned event input, or command if free.
// - With event assigned, run request is a monitor; key writes ignored.
// - Pattern set to off drops the event input start assignment.
// - Each start and reset pulses a nonvolatile write request.
// - After the end, display toggles set point and end every 0.5 s.
// - End signal mappable to any output and shown in status.
// - Run request back to cleared drops end output and end display.
// - A start switches run/stop to run.
// - A reset before the soak ends switches run/stop to stop.
// - Manual run/stop during a run keeps the accumulated soak time.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sps_top #(
  parameter int unsigned HALF_CYC = sps_pkg::HALF_S_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire sps_pkg::sps_apb_req_t      apb_req,
  output var  sps_pkg::sps_apb_rsp_t      apb_rsp,
  input  wire logic                       event_pin,
  input  wire logic signed [15:0]         process_value,
  input  wire logic signed [15:0]         set_point,
  input  wire logic [sps_pkg::NOUT-1:0]   ctl_out,
  output var  logic [sps_pkg::NOUT-1:0]   phys_out,
  output var  logic                       program_end,
  output var  logic                       show_end,
  output var  logic                       run_state,
  output var  logic                       nvm_write_req
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sps_pkg::sps_phase_t      phase;
    sps_pkg::sps_pattern_t    program_pattern_select;
    logic                     program_run_request;
    logic                     unit_hours;
    logic                     evt_assign;
    logic                     analog_in;
    logic                     run;
    logic [13:0]              soak_duration;
    logic [13:0]              band;
    logic [13:0]              elapsed;
    logic [sps_pkg::NOUT-1:0] out_map;
    logic [sps_pkg::NOUT-1:0] phys;
    logic                     end_flag;
    logic                     alt;
    logic                     nvm_wr;
    logic                     evt_prev;
    logic [31:0]              rdata;
  } sps_top_st_t;

  sps_top_st_t s;
  sps_top_st_t next_s;

  logic        evt_level;
  logic        half_tick;
  logic        unit_tick;
  logic        in_band;
  logic        setup;
  logic        access;
  logic        start;
  logic        clear;
  logic [31:0] wd;
  logic [16:0] diff;
  logic [16:0] mag;
  logic [13:0] soak_remaining_monitor;

  localparam int unsigned CTRL_PAT_HI = sps_pkg::CTRL_PAT_LO + 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == sps_pkg::OFF_CTRL)   || (a == sps_pkg::OFF_SOAK)   ||
              (a == sps_pkg::OFF_BAND)   || (a == sps_pkg::OFF_CMD)    ||
              (a == sps_pkg::OFF_STATUS) || (a == sps_pkg::OFF_REMAIN) ||
              (a == sps_pkg::OFF_OUTMAP);
  endfunction

  function automatic logic pattern_on(input sps_pkg::sps_pattern_t p);
    pattern_on = (p == sps_pkg::SPS_PAT_STOP_AT_FINISH) ||
                 (p == sps_pkg::SPS_KEEP_RUNNING_AT_FINISH);
  endfunction

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  sps_sync #(
    .W (1)
  ) u_evt_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (event_pin),
    .level (evt_level)
  );

  sps_tick_gen #(
    .HALF_CYC    (HALF_CYC),
    .MIN_HALVES  (sps_pkg::MIN_HALVES),
    .HOUR_HALVES (sps_pkg::HOUR_HALVES)
  ) u_tick (
    .clk       (clk),
    .rst_b     (rst_b),
    .en        ((s.phase == sps_pkg::SPS_SOAK) && in_band),
    .clr       (s.phase != sps_pkg::SPS_SOAK),
    .hours     (s.unit_hours),
    .half_tick (half_tick),
    .unit_tick (unit_tick)
  );

  // ---------------------------------------------------------------
  // Band check
  // ---------------------------------------------------------------
  always_comb begin
    diff    = 17'({process_value[15], process_value} -
                   {set_point[15], set_point});
    mag     = diff[16] ? 17'(-diff) : diff;
    in_band = (s.band == sps_pkg::BAND_OFF) ||
              (mag <= {3'h0, s.band});
  end

  always_comb begin
    unique case (s.phase)
      sps_pkg::SPS_SOAK: soak_remaining_monitor = 14'(s.soak_duration -
                                                      s.elapsed);
      sps_pkg::SPS_DONE: soak_remaining_monitor = 14'h0000;
      default:           soak_remaining_monitor = s.soak_duration;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Reset wins over a start seen in the same cycle
  always_comb begin
    next_s          = s;
    setup           = apb_req.psel && !apb_req.penable;
    access          = apb_req.psel && apb_req.penable;
    wd              = apb_req.pwdata;
    start           = 1'b0;
    clear           = 1'b0;
    next_s.nvm_wr   = 1'b0;
    next_s.evt_prev = evt_level;

    if (access && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        sps_pkg::OFF_CTRL: begin
          if (wd[CTRL_PAT_HI:sps_pkg::CTRL_PAT_LO] != 2'h3) begin
            next_s.program_pattern_select =
              sps_pkg::sps_pattern_t'(wd[CTRL_PAT_HI:sps_pkg::CTRL_PAT_LO]);
          end
          next_s.unit_hours = wd[sps_pkg::CTRL_HOURS];
          next_s.analog_in  = wd[sps_pkg::CTRL_ANALOG];
          next_s.evt_assign = wd[sps_pkg::CTRL_EVT];
          next_s.run        = wd[sps_pkg::CTRL_RUN];
          if (!s.evt_assign) begin
            start = wd[sps_pkg::CTRL_REQ] && !s.program_run_request;
            clear = !wd[sps_pkg::CTRL_REQ] && s.program_run_request;
          end
        end
        sps_pkg::OFF_SOAK: begin
          if (wd[13:0] >= sps_pkg::SOAK_MIN && wd[13:0] <= sps_pkg::SOAK_MAX
              && wd[31:14] == 18'h00000) begin
            next_s.soak_duration = wd[13:0];
          end
        end
        sps_pkg::OFF_BAND: begin
          if (wd[13:0] <= sps_pkg::BAND_MAX && wd[31:14] == 18'h00000) begin
            next_s.band = wd[13:0];
          end
        end
        sps_pkg::OFF_CMD: begin
          if (!s.evt_assign) begin
            start = wd[sps_pkg::CMD_START] && !s.program_run_request;
            clear = wd[sps_pkg::CMD_RESET] && s.program_run_request;
          end
        end
        sps_pkg::OFF_OUTMAP: next_s.out_map = wd[sps_pkg::NOUT-1:0];
        default: ;
      endcase
    end

    if (!pattern_on(next_s.program_pattern_select)) begin
      next_s.evt_assign = 1'b0;
    end

    if (s.evt_assign) begin
      start = evt_level && !s.evt_prev && !s.program_run_request;
      clear = !evt_level && s.evt_prev && s.program_run_request;
    end

    if (!pattern_on(s.program_pattern_select)) begin
      start              = 1'b0;
      next_s.phase       = sps_pkg::SPS_IDLE;
      next_s.end_flag    = 1'b0;
      next_s.alt         = 1'b0;
      next_s.elapsed     = '0;
    end

    if (clear) begin
      next_s.program_run_request = 1'b0;
      next_s.nvm_wr              = 1'b1;
      next_s.end_flag            = 1'b0;
      next_s.alt                 = 1'b0;
      next_s.elapsed             = '0;
      next_s.phase               = sps_pkg::SPS_IDLE;
      if (s.phase == sps_pkg::SPS_SOAK) begin
        next_s.run = 1'b0;
      end
    end else if (start) begin
      next_s.program_run_request = 1'b1;
      next_s.nvm_wr              = 1'b1;
      next_s.run                 = 1'b1;
      next_s.end_flag            = 1'b0;
      next_s.alt                 = 1'b0;
      next_s.elapsed             = '0;
      next_s.phase               = sps_pkg::SPS_SOAK;
    end else begin
      unique case (s.phase)
        sps_pkg::SPS_IDLE: ;
        sps_pkg::SPS_SOAK: begin
          if (s.elapsed >= s.soak_duration) begin
            next_s.phase    = sps_pkg::SPS_DONE;
            next_s.end_flag = 1'b1;
            next_s.alt      = 1'b1;
            if (s.program_pattern_select ==
                sps_pkg::SPS_PAT_STOP_AT_FINISH) begin
              next_s.run = 1'b0;
            end else begin
              next_s.run = 1'b1;
            end
          end else if (unit_tick) begin
            next_s.elapsed = 14'(s.elapsed + 1'b1);
          end
        end
        sps_pkg::SPS_DONE: begin
          if (half_tick) begin
            next_s.alt = !s.alt;
          end
        end
      endcase
    end

    next_s.phys = (ctl_out & ~s.out_map) |
                  (s.out_map & {sps_pkg::NOUT{s.end_flag}});

    if (setup) begin
      unique case (apb_req.paddr)
        sps_pkg::OFF_CTRL: next_s.rdata = {25'h0000000, s.run,
                                   s.analog_in, s.evt_assign, s.unit_hours,
                                   s.program_run_request,
                                   s.program_pattern_select};
        sps_pkg::OFF_SOAK:   next_s.rdata = {18'h00000, s.soak_duration};
        sps_pkg::OFF_BAND:   next_s.rdata = {18'h00000, s.band};
        sps_pkg::OFF_STATUS: next_s.rdata = {26'h0000000,
                                   s.program_run_request, s.alt, in_band,
                                   s.phase == sps_pkg::SPS_SOAK, s.run,
                                   s.end_flag};
        sps_pkg::OFF_REMAIN: next_s.rdata = {18'h00000,
                                   soak_remaining_monitor};
        sps_pkg::OFF_OUTMAP: next_s.rdata = {24'h000000, s.out_map};
        default:             next_s.rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s               <= '0;
      s.soak_duration <= sps_pkg::SOAK_RESET;
      s.band          <= sps_pkg::BAND_OFF;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero wait states: read data was latched in the setup cycle
  always_comb begin
    apb_rsp.pready  = access;
    apb_rsp.pslverr = access && !addr_ok(apb_req.paddr);
    apb_rsp.prdata  = s.rdata;
  end

  assign phys_out      = s.phys;
  assign program_end   = s.end_flag;
  assign show_end      = s.alt;
  assign run_state     = s.run;
  assign nvm_write_req = s.nvm_wr;

endmodule
`default_nettype wire

/* dv/sps_ext_model.sv */
// Far-side model: event contact, process value and write budget
`timescale 1ns/1ps
`default_nettype none
module sps_ext_model (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               ev_req,
  input  wire logic signed [15:0] set_point,
  input  wire logic signed [15:0] offset,
  input  wire logic               nvm_write_req,
  output var  logic               event_pin,
  output var  logic signed [15:0] process_value,
  output var  int                 nvm_count
);
  // ------------
  // Behaviour
  // ------------
  // Contact follows the request one edge late, as a relay would
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_pin     <= 1'b0;
      process_value <= 16'sh0000;
      nvm_count     <= 0;
    end else begin
      event_pin     <= ev_req;
      process_value <= set_point + offset;
      // Counted so a run can be judged against the write endurance
      nvm_count     <= nvm_count + int'(nvm_write_req);
    end
  end
endmodule
`default_nettype wire

/* dv/sps_top_asserts.sv */
// Assertion checker on the ports of the sequencer top
`timescale 1ns/1ps
`default_nettype none
module sps_top_asserts #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire sps_pkg::sps_apb_req_t    apb_req,
  input wire sps_pkg::sps_apb_rsp_t    apb_rsp,
  input wire logic                     event_pin,
  input wire logic signed [15:0]       process_value,
  input wire logic signed [15:0]       set_point,
  input wire logic [sps_pkg::NOUT-1:0] ctl_out,
  input wire logic [sps_pkg::NOUT-1:0] phys_out,
  input wire logic                     program_end,
  input wire logic                     show_end,
  input wire logic                     run_state,
  input wire logic                     nvm_write_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ------------
  // Shadows of APB writes and end display history
  // ------------
  logic        wr;
  logic [7:0]  map;
  logic [1:0]  pat;
  logic        show_q;
  int unsigned cnt;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite
              && apb_rsp.pready;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map    <= 8'h00;
      pat    <= 2'h0;
      show_q <= 1'b0;
      cnt    <= 0;
    end else begin
      if (wr && apb_req.paddr == sps_pkg::OFF_OUTMAP) begin
        map <= apb_req.pwdata[7:0];
      end
      // Pattern 3 is refused, so the shadow keeps the old pattern
      if (wr && apb_req.paddr == sps_pkg::OFF_CTRL
          && apb_req.pwdata[1:0] != 2'h3) begin
        pat <= apb_req.pwdata[1:0];
      end
      show_q <= show_end;
      cnt    <= (program_end && show_end == show_q) ? cnt + 1 : 0;
    end
  end
  // ------------
  // Properties
  // ------------
  sequence s_end_rise;
    $rose(program_end);
  endsequence
  a_end_shows: assert property (s_end_rise |-> show_end)
    else $error("end display missing at end");
  a_end_clears: assert property ($fell(program_end) |-> !show_end)
    else $error("end display left on");
  a_show_needs_end: assert property (show_end |-> program_end)
    else $error("end display without end");
  a_blink_gap: assert property (program_end |-> cnt < HALF_CYC)
    else $error("end display stopped alternating");
  a_nvm_pulse: assert property (nvm_write_req |=> !nvm_write_req)
    else $error("write request too long");
  a_phys_map: assert property ($past(rst_b) |->
      phys_out == $past((map & {8{program_end}}) | (~map & ctl_out)))
    else $error("mapped output wrong");
  a_off_idle: assert property ((pat == 2'h0) [*2] |-> !program_end)
    else $error("end with pattern off");
  a_stop_finish: assert property (
      (pat == 2'h1) ##0 s_end_rise |-> !run_state)
    else $error("still running at end");
  a_keep_finish: assert property (
      (pat == 2'h2) ##0 s_end_rise |-> run_state)
    else $error("stopped at end");
endmodule
bind sps_top sps_top_asserts #(.HALF_CYC(HALF_CYC)) u_chk (
  .clk, .rst_b, .apb_req, .apb_rsp, .event_pin, .process_value,
  .set_point, .ctl_out, .phys_out, .program_end, .show_end, .run_state,
  .nvm_write_req);
`default_nettype wire

/* dv/test_soak_program_sequencer.sv */
// Self-checking testbench of the soak program sequencer
`timescale 1ns/1ps
`default_nettype none
module test_soak_program_sequencer;
  // ------------
  // Signals; half second cut to 4 cycles, a minute to 480
  // ------------
  localparam int unsigned H    = 4;
  localparam int unsigned UNIT = 120 * H;
  logic                  clk;
  logic                  rst_b;
  sps_pkg::sps_apb_req_t req;
  sps_pkg::sps_apb_rsp_t rsp;
  logic                  ev_req;
  logic                  ev;
  logic signed [15:0]    sp;
  logic signed [15:0]    off;
  logic signed [15:0]    pv;
  logic [7:0]            ctl;
  logic [7:0]            phys;
  logic [7:0]            omap;
  logic                  pend;
  logic                  shw;
  logic                  run;
  logic                  nvm;
  int                    nvm_cnt;
  int                    n_fail;
  int                    n_checks;
  logic [31:0]           rd;
  logic                  err;
  sps_top #(.HALF_CYC(H)) uut (
    .clk, .rst_b, .apb_req(req), .apb_rsp(rsp), .event_pin(ev),
    .process_value(pv), .set_point(sp), .ctl_out(ctl), .phys_out(phys),
    .program_end(pend), .show_end(shw), .run_state(run),
    .nvm_write_req(nvm));
  sps_ext_model far (
    .clk, .rst_b, .ev_req, .set_point(sp), .offset(off),
    .nvm_write_req(nvm), .event_pin(ev), .process_value(pv),
    .nvm_count(nvm_cnt));
  // ------------
  // Tasks
  // ------------
  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // Called just after a rising edge; returns just after one
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 16);
    if (rsp.pready !== 1'b1) begin
      n_fail++;
      summarize();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wctl(input logic [31:0] d);
    apb(1'b1, sps_pkg::OFF_CTRL, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Returns at the falling edge where the end output is first seen
  task automatic wait_end(input int lim, output int t);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (pend !== 1'b1 && t < lim);
    if (t >= lim) begin
      n_fail++;
      summarize();
    end
  endtask
  function automatic logic [7:0] phys_exp(input logic [7:0] m,
                                          input logic e,
                                          input logic [7:0] c);
    return (m & {8{e}}) | (~m & c);
  endfunction
  // ------------
  // Clock and sequence
  // ------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    int t;
    logic b;
    logic [31:0] v;
    rst_b = 1'b0;
    req = '0;
    ev_req = 1'b0;
    sp = 16'sh0000;
    off = 16'sh0000;
    ctl = 8'h00;
    n_fail = 0;
    n_checks = 0;
    v = $urandom(38390);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      rdr(8'(4 * k));
      chk("reset value", rd, {28'h0, k == 4, 2'h0, k == 1 | k == 5});
    end
    rdr(8'h1C);
    chk("unmapped error", err, 32'h1);
    apb(1'b1, sps_pkg::OFF_BAND, 32'h2710);
    rdr(sps_pkg::OFF_BAND);
    chk("band above range", rd, 32'h0);
    apb(1'b1, sps_pkg::OFF_BAND, 32'h270F);
    rdr(sps_pkg::OFF_BAND);
    chk("band at top", rd, 32'h270F);
    apb(1'b1, sps_pkg::OFF_SOAK, 32'h0);
    rdr(sps_pkg::OFF_SOAK);
    chk("duration zero", rd, 32'h1);
    // Pattern off: key and command requests do nothing
    omap = 8'($urandom);
    ctl <= 8'($urandom);
    sp <= 16'($urandom_range(0, 4000));
    off <= 16'sh0BB8;
    apb(1'b1, sps_pkg::OFF_OUTMAP, 32'(omap));
    apb(1'b1, sps_pkg::OFF_BAND, 32'h0);
    wctl(32'h4);
    apb(1'b1, sps_pkg::OFF_CMD, 32'h1);
    repeat (UNIT + 8) @(posedge clk);
    @(negedge clk);
    chk("pattern off", {pend, run}, 2'b00);
    @(posedge clk);
    // Stop pattern, band off, far from set point
    wctl(32'h1);
    v = 32'(nvm_cnt);
    wctl(32'h5);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("run at start", run, 1'b1);
    chk("write on start", nvm_cnt, v + 1);
    wait_end(2 * UNIT, t);
    chk("end shown", {pend, shw}, 2'b11);
    chk("stopped at end", run, 1'b0);
    chk("band off timing", t >= UNIT - H - 4 && t <= UNIT + 2, 1'b1);
    @(negedge clk);
    chk("end on output", phys, phys_exp(omap, 1'b1, ctl));
    b = shw;
    v = 0;
    repeat (4 * H) begin
      @(negedge clk);
      v += 32'(shw !== b);
      b = shw;
    end
    chk("display changes", v, 32'h4);
    @(posedge clk);
    rdr(sps_pkg::OFF_STATUS);
    chk("end in status", rd[0], 1'b1);
    wctl(32'h1);
    @(negedge clk);
    chk("end cleared", {pend, shw}, 2'b00);
    @(posedge clk);
    // Keep pattern, command start, leaving and re-entering the band
    apb(1'b1, sps_pkg::OFF_SOAK, 32'h2);
    apb(1'b1, sps_pkg::OFF_BAND, 32'h1E);
    off <= -16'sh1E;
    wctl(32'h42);
    apb(1'b1, sps_pkg::OFF_CMD, 32'h1);
    repeat (UNIT + 2 * H) @(posedge clk);
    rdr(sps_pkg::OFF_REMAIN);
    chk("remain after a unit", rd, 32'h1);
    off <= 16'sh1F;
    rdr(sps_pkg::OFF_CTRL);
    v = rd;
    wctl(v & ~32'h40);
    @(negedge clk);
    chk("manual stop", run, 1'b0);
    @(posedge clk);
    repeat (UNIT + 2 * H) @(posedge clk);
    rdr(sps_pkg::OFF_REMAIN);
    chk("held out of band", rd, 32'h1);
    off <= 16'sh0000;
    wctl(v | 32'h40);
    wait_end(2 * UNIT, t);
    chk("keep running", {pend, run}, 2'b11);
    @(posedge clk);
    apb(1'b1, sps_pkg::OFF_CMD, 32'h2);
    @(negedge clk);
    chk("command reset", {pend, run}, 2'b01);
    @(posedge clk);
    // Stop pattern, reset before the soak ends, random in-band value
    wctl(32'h41);
    wctl(32'h45);
    repeat (UNIT + 2 * H) begin
      off <= 16'($urandom_range(0, 60)) - 16'sh1E;
      @(posedge clk);
    end
    rdr(sps_pkg::OFF_REMAIN);
    chk("remain in band", rd, 32'h1);
    v = 32'(nvm_cnt);
    wctl(32'h41);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("stop on early reset", run, 1'b0);
    chk("write on reset", nvm_cnt, v + 1);
    @(posedge clk);
    rdr(sps_pkg::OFF_REMAIN);
    chk("timer cleared", rd, 32'h2);
    // Event input owns the start; key and command are refused
    wctl(32'h11);
    ev_req <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("event start runs", run, 1'b1);
    @(posedge clk);
    wctl(32'h51);
    apb(1'b1, sps_pkg::OFF_CMD, 32'h2);
    rdr(sps_pkg::OFF_CTRL);
    chk("event start shown", rd[2], 1'b1);
    ev_req <= 1'b0;
    repeat (8) @(posedge clk);
    rdr(sps_pkg::OFF_CTRL);
    chk("event reset shown", rd[2], 1'b0);
    wctl(32'h10);
    rdr(sps_pkg::OFF_CTRL);
    chk("event released", rd[4], 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
